// *** src/bcsm_pkg.sv ***
// Purpose: shared constants and types of the battery charge sequencer
// Assumes: 125 MHz system clock, voltages in millivolts, currents in milliamps
// Notes:   derived cycle counts are defaults of the top module parameters
package bcsm_pkg;

  localparam int unsigned CLK_HZ                = 125_000_000;
  localparam int unsigned ONE_SECOND_S          = 1;
  localparam int unsigned SEC_CYCLES_DEF        = CLK_HZ * ONE_SECOND_S;
  localparam int unsigned BULK_MAX_DWELL_MIN    = 3;
  localparam int unsigned BULK_MAX_DWELL_S      = BULK_MAX_DWELL_MIN * 60;
  localparam int unsigned BULK_RETURN_DWELL_MIN = 10;
  localparam int unsigned BULK_RETURN_DWELL_S   = BULK_RETURN_DWELL_MIN * 60;
  localparam int unsigned EQUALISE_LIMIT_DAYS   = 4;
  localparam int unsigned EQUALISE_LIMIT_S      = EQUALISE_LIMIT_DAYS * 24 * 3600;
  localparam logic [4:0]  EQUALISE_START_HOUR   = 5'h09;
  localparam int unsigned LONG_PUSH_MS          = 1000;
  localparam int unsigned LONG_CYCLES_DEF       = CLK_HZ / 1000 * LONG_PUSH_MS;
  localparam int unsigned DEBOUNCE_MS           = 10;
  localparam int unsigned DEBOUNCE_CYCLES_DEF   = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned QUICK_GAP_MS          = 400;
  localparam int unsigned QUICK_CYCLES_DEF      = CLK_HZ / 1000 * QUICK_GAP_MS;
  localparam int unsigned FAST_IDLE_MS          = 1000;
  localparam int unsigned IDLE_CYCLES_DEF       = CLK_HZ / 1000 * FAST_IDLE_MS;
  localparam logic [2:0]  FAST_PUSH_COUNT       = 3'h5;
  localparam logic [15:0] FAST_STEP             = 16'h000a;
  localparam logic [15:0] SLOW_STEP             = 16'h0001;
  localparam int unsigned MENU_ITEMS            = 7;
  localparam int unsigned SUB_ITEMS             = 4;
  localparam logic [2:0]  ITEM_BATTERY_VOLTAGE  = 3'h0;
  localparam logic [2:0]  ITEM_TOTAL_CHARGE     = 3'h1;
  localparam logic [7:0]  FULL_DUTY             = 8'hff;
  localparam logic [7:0]  HOT_DUTY              = 8'h80;

  typedef enum logic [1:0] {
    bulk_state,
    equalise_state,
    hold_state,
    maintain_state
  } bcsm_chg_t;

  typedef enum logic [2:0] {
    LVL_TOP,
    LVL_REGSTATE,
    LVL_SUB,
    LVL_EDIT_FLASH,
    LVL_EDIT_HOLD
  } bcsm_level_t;

  typedef struct packed {
    logic [15:0] bulk_max_voltage;
    logic [15:0] bulk_return_voltage;
    logic [15:0] equalise_voltage;
    logic [15:0] hold_voltage;
    logic [15:0] maintain_voltage;
    logic [15:0] hysteresis_margin;
    logic [15:0] equalise_duration;
    logic [15:0] hold_duration;
    logic [7:0]  bulk_interval_days;
    logic [7:0]  equalise_interval_days;
  } bcsm_cfg_t;

  typedef struct packed {
    logic short_push;
    logic long_push;
  } bcsm_push_t;

endpackage : bcsm_pkg

// *** src/bcsm_button.sv ***
// Purpose: front button synchroniser, debouncer and push classifier
// Assumes: button pin is active low and asynchronous to CLK
// Notes:   long push fires while still held, short push fires on release
`timescale 1ns/1ps
module bcsm_button
  import bcsm_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF,
  parameter int unsigned LONG_CYCLES     = LONG_CYCLES_DEF
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // pin side
  input  wire logic       button_n,
  // classified pushes
  output bcsm_push_t      push
);

  logic        sync1;
  logic        sync2;
  logic        stable;
  logic [31:0] db_cnt;
  logic [31:0] hold_cnt;
  logic        long_done;
  wire         raw_pressed = ~sync2;
  wire         db_settled  = db_cnt >= DEBOUNCE_CYCLES - 1;
  wire         press_edge  = raw_pressed && !stable && db_settled;
  wire         release_edge = !raw_pressed && stable && db_settled;
  wire         long_hit    = stable && !long_done && hold_cnt >= LONG_CYCLES - 1;

  generate
    if (DEBOUNCE_CYCLES < 1 || LONG_CYCLES <= DEBOUNCE_CYCLES)
    begin : g_bad
      $error("bcsm_button: long push must outlast the debounce time");
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end
    else
    begin
      sync1 <= button_n;
      sync2 <= sync1;
    end
  end

  // level must hold unchanged for the whole window, so bounce never flips it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stable <= 1'b0;
      db_cnt <= 32'h0;
    end
    else if (raw_pressed == stable)
    begin
      db_cnt <= 32'h0;
    end
    else if (db_settled)
    begin
      stable <= raw_pressed;
      db_cnt <= 32'h0;
    end
    else
    begin
      db_cnt <= db_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_cnt  <= 32'h0;
      long_done <= 1'b0;
      push      <= '0;
    end
    else
    begin
      push.long_push  <= long_hit;
      push.short_push <= release_edge && !long_done;
      if (press_edge)
      begin
        hold_cnt  <= 32'h0;
        long_done <= 1'b0;
      end
      else if (stable && !long_done)
      begin
        hold_cnt  <= hold_cnt + 32'h1;
        long_done <= long_hit;
      end
    end
  end

endmodule : bcsm_button

// *** src/bcsm_top.sv ***
// Purpose: charge regulation sequencer with single button menu decoder
// Assumes: battery and current readings and hour of day come from CLK logic
// Notes:   only OVERHEAT and the button pin are asynchronous and synchronised
//
// Functional notes
// - bulk moves on after voltage holds at bulk maximum for 3 minutes
// - bulk passes all charge current, no downward voltage regulation
// - later states return to bulk after over 10 minutes below return level
// - bulk cycle forced after configured day count, regardless of voltage
// - on state screen long push advances state, short push returns
// - zero equalise or hold duration bypasses that state
// - state screen shows voltage in bulk/maintain, timer in equalise/hold
// - equalise or hold timer reaching its duration advances the state
// - equalise holds equalise voltage for its duration, every interval days
// - scheduled equalise starts at 9am on its due day
// - equalise ends after 4 days even if voltage never reached
// - hold regulates at hold voltage for hold duration, then maintain
// - hold timer runs only above hold voltage minus hysteresis, else pauses
// - maintain re-enables charging whenever battery drops below its setpoint
// - held about one second is long push, brief press is short push
// - long push flashes value, short pushes step it, long push stores
// - long push stops flashing, another resumes with reversed step direction
// - five quick short pushes enter fast steps, one idle second exits
// - top level cycles seven items, long push enters submenu, or the state screen from the voltage item
// - short pushes lead back to top level, except while adjusting
// - total charge current is internal plus external charge current
// - voltage screen after power-up, charge current reduced when board hot
`timescale 1ns/1ps
module bcsm_top
  import bcsm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES      = SEC_CYCLES_DEF,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF,
  parameter int unsigned LONG_CYCLES     = LONG_CYCLES_DEF,
  parameter int unsigned QUICK_CYCLES    = QUICK_CYCLES_DEF,
  parameter int unsigned IDLE_CYCLES     = IDLE_CYCLES_DEF
)(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // measurements and time of day
  input  wire logic [15:0] BATTERY_MV,
  input  wire logic [15:0] INTERNAL_CHARGE_CURRENT,
  input  wire logic [15:0] EXTERNAL_CHARGE_CURRENT,
  input  wire logic [4:0]  TIME_HOUR,
  input  wire logic        OVERHEAT,
  // settings
  input  bcsm_cfg_t        CFG,
  input  wire logic [15:0] EDIT_INIT,
  // front panel
  input  wire logic        BUTTON_N,
  // regulation outputs
  output bcsm_chg_t        CHARGE_STATE,
  output logic             CHARGE_ON,
  output logic [7:0]       CHARGE_DUTY,
  output logic [16:0]      TOTAL_CURRENT,
  // display and menu outputs
  output bcsm_level_t      MENU_LEVEL,
  output logic [2:0]       MENU_ITEM,
  output logic [1:0]       MENU_SUB,
  output logic [16:0]      DISP_VALUE,
  output logic             DISP_FLASH,
  output logic             FAST_MODE,
  output logic [15:0]      EDIT_VALUE,
  output logic             EDIT_STORE
);

  generate
    if (SEC_CYCLES < 2 || QUICK_CYCLES < 1 || IDLE_CYCLES <= QUICK_CYCLES)
    begin : g_bad
      $error("bcsm_top: timing parameters out of range");
    end
  endgenerate

  function automatic bcsm_chg_t after_chg(input bcsm_chg_t cur, input logic with_eq,
                                           input logic eq_zero, input logic hold_zero);
    case (cur)
      bulk_state:     after_chg = (with_eq && !eq_zero) ? equalise_state :
                                  (hold_zero ? maintain_state : hold_state);
      equalise_state: after_chg = hold_zero ? maintain_state : hold_state;
      hold_state:     after_chg = maintain_state;
      maintain_state: after_chg = bulk_state;
      default:        after_chg = bulk_state;
    endcase
  endfunction : after_chg

  bcsm_push_t  push;
  logic        hot_s1;
  logic        hot_s2;
  logic [31:0] sec_cnt;
  logic [4:0]  hour_prev;
  logic [7:0]  days_bulk;
  logic [7:0]  days_eq;
  logic [15:0] above_bulk_max_voltage_s;
  logic [15:0] below_bulk_return_voltage_s;
  logic [5:0]  state_sec;
  logic [15:0] state_min;
  logic [31:0] eq_total_s;
  bcsm_chg_t   chg;
  bcsm_chg_t   next_chg;
  bcsm_level_t level;
  bcsm_level_t next_level;
  logic [2:0]  item;
  logic [2:0]  next_item;
  logic [1:0]  sub;
  logic [1:0]  next_sub;
  logic [31:0] quiet_cnt;
  logic [2:0]  short_run;
  logic        fast;
  logic        step_down;
  logic [15:0] edit_val;

  bcsm_button #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES),
    .LONG_CYCLES     (LONG_CYCLES)
  ) u_button (
    .clk      (CLK),
    .rst_n    (RSTN),
    .button_n (BUTTON_N),
    .push     (push)
  );

  // regulation decode
  wire        sec_tick    = sec_cnt == SEC_CYCLES - 1;
  wire        day_tick    = TIME_HOUR == 5'h00 && hour_prev != 5'h00;
  wire        eq_zero     = CFG.equalise_duration == 16'h0;
  wire        hold_zero   = CFG.hold_duration == 16'h0;
  wire        at_bulk_max_voltage     = BATTERY_MV >= CFG.bulk_max_voltage;
  wire        below_bulk_return_voltage  = BATTERY_MV < CFG.bulk_return_voltage;
  wire [16:0] batt_hysteresis_margin   = {1'b0, BATTERY_MV} + {1'b0, CFG.hysteresis_margin};
  wire        eq_run      = batt_hysteresis_margin > {1'b0, CFG.equalise_voltage};
  wire        hold_run    = batt_hysteresis_margin > {1'b0, CFG.hold_voltage};
  wire        timer_run   = (chg == equalise_state && eq_run) || (chg == hold_state && hold_run);
  wire        bulk_done   = chg == bulk_state && above_bulk_max_voltage_s >= BULK_MAX_DWELL_S;
  wire        back_bulk   = chg != bulk_state && below_bulk_return_voltage_s > BULK_RETURN_DWELL_S;
  wire        bulk_due    = CFG.bulk_interval_days != 8'h0 &&
                            days_bulk >= CFG.bulk_interval_days;
  wire        eq_due      = !eq_zero && CFG.equalise_interval_days != 8'h0 &&
                            days_eq >= CFG.equalise_interval_days &&
                            TIME_HOUR == EQUALISE_START_HOUR;
  wire        eq_done     = chg == equalise_state &&
                            (state_min >= CFG.equalise_duration ||
                             eq_total_s >= EQUALISE_LIMIT_S);
  wire        hold_done   = chg == hold_state && state_min >= CFG.hold_duration;
  wire        manual_adv  = level == LVL_REGSTATE && push.long_push;
  wire        chg_change  = next_chg != chg;
  wire        want_charge = chg == bulk_state ? 1'b1 :
                            chg == equalise_state ? BATTERY_MV < CFG.equalise_voltage :
                            chg == hold_state ? BATTERY_MV < CFG.hold_voltage :
                            BATTERY_MV < CFG.maintain_voltage;

  always_comb
  begin
    next_chg = chg;
    if (eq_due && chg != equalise_state)
      next_chg = equalise_state;
    else if (bulk_due || back_bulk)
      next_chg = bulk_state;
    else if (manual_adv)
      next_chg = after_chg(chg, 1'b1, eq_zero, hold_zero);
    else if (bulk_done || eq_done || hold_done)
      next_chg = after_chg(chg, 1'b0, eq_zero, hold_zero);
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hot_s1    <= 1'b0;
      hot_s2    <= 1'b0;
      sec_cnt   <= 32'h0;
      hour_prev <= 5'h00;
    end
    else
    begin
      hot_s1    <= OVERHEAT;
      hot_s2    <= hot_s1;
      sec_cnt   <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
      hour_prev <= TIME_HOUR;
    end
  end

  // day counters restart when their cycle begins
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      days_bulk <= 8'h00;
      days_eq   <= 8'h00;
    end
    else
    begin
      if (chg_change && next_chg == bulk_state)
        days_bulk <= 8'h00;
      else if (day_tick && days_bulk != 8'hff)
        days_bulk <= days_bulk + 8'h01;
      if (chg_change && next_chg == equalise_state)
        days_eq <= 8'h00;
      else if (day_tick && days_eq != 8'hff)
        days_eq <= days_eq + 8'h01;
    end
  end

  // dwell counters need the level unbroken, so a dip restarts them
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      above_bulk_max_voltage_s <= 16'h0;
      below_bulk_return_voltage_s <= 16'h0;
    end
    else
    begin
      if (!at_bulk_max_voltage || chg_change)
        above_bulk_max_voltage_s <= 16'h0;
      else if (sec_tick && above_bulk_max_voltage_s != 16'hffff)
        above_bulk_max_voltage_s <= above_bulk_max_voltage_s + 16'h1;
      if (!below_bulk_return_voltage || chg_change)
        below_bulk_return_voltage_s <= 16'h0;
      else if (sec_tick && below_bulk_return_voltage_s != 16'hffff)
        below_bulk_return_voltage_s <= below_bulk_return_voltage_s + 16'h1;
    end
  end

  // state timer pauses without clearing; the 4 day guard never pauses
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_sec  <= 6'h00;
      state_min  <= 16'h0;
      eq_total_s <= 32'h0;
    end
    else if (chg_change)
    begin
      state_sec  <= 6'h00;
      state_min  <= 16'h0;
      eq_total_s <= 32'h0;
    end
    else if (sec_tick)
    begin
      if (chg == equalise_state)
        eq_total_s <= eq_total_s + 32'h1;
      if (timer_run)
      begin
        state_sec <= state_sec == 6'h3b ? 6'h00 : state_sec + 6'h01;
        if (state_sec == 6'h3b && state_min != 16'hffff)
          state_min <= state_min + 16'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      chg           <= bulk_state;
      CHARGE_STATE  <= bulk_state;
      CHARGE_ON     <= 1'b0;
      CHARGE_DUTY   <= FULL_DUTY;
      TOTAL_CURRENT <= 17'h0;
    end
    else
    begin
      chg           <= next_chg;
      CHARGE_STATE  <= next_chg;
      CHARGE_ON     <= want_charge;
      CHARGE_DUTY   <= hot_s2 ? HOT_DUTY : FULL_DUTY;
      TOTAL_CURRENT <= {1'b0, INTERNAL_CHARGE_CURRENT} +
                       {1'b0, EXTERNAL_CHARGE_CURRENT};
    end
  end

  // menu decode
  wire        quick      = quiet_cnt < QUICK_CYCLES;
  wire [2:0]  next_run   = quick ? (short_run == FAST_PUSH_COUNT ? short_run :
                                    short_run + 3'h1) : 3'h1;
  wire [15:0] step       = fast ? FAST_STEP : SLOW_STEP;
  wire [15:0] val_up     = edit_val > 16'hffff - step ? 16'hffff : edit_val + step;
  wire [15:0] val_down   = edit_val < step ? 16'h0 : edit_val - step;
  wire        in_edit    = level == LVL_EDIT_FLASH;
  wire [2:0]  item_inc   = item == 3'(MENU_ITEMS - 1) ? 3'h0 : item + 3'h1;

  always_comb
  begin
    next_level = level;
    next_item  = item;
    next_sub   = sub;
    if (push.short_push)
    begin
      case (level)
        LVL_TOP:      next_item = item_inc;
        LVL_REGSTATE: next_level = LVL_TOP;
        LVL_SUB:
        begin
          if (sub == 2'(SUB_ITEMS - 1))
            next_level = LVL_TOP;
          else
            next_sub = sub + 2'h1;
        end
        LVL_EDIT_FLASH: next_level = LVL_EDIT_FLASH;
        LVL_EDIT_HOLD:  next_level = LVL_SUB;
        default:        next_level = LVL_TOP;
      endcase
    end
    else if (push.long_push)
    begin
      case (level)
        LVL_TOP:
        begin
          next_level = item == ITEM_BATTERY_VOLTAGE ? LVL_REGSTATE : LVL_SUB;
          next_sub   = 2'h0;
        end
        LVL_REGSTATE:   next_level = LVL_REGSTATE;
        LVL_SUB:        next_level = LVL_EDIT_FLASH;
        LVL_EDIT_FLASH: next_level = LVL_EDIT_HOLD;
        LVL_EDIT_HOLD:  next_level = LVL_EDIT_FLASH;
        default:        next_level = LVL_TOP;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      level <= LVL_TOP;
      item  <= ITEM_BATTERY_VOLTAGE;
      sub   <= 2'h0;
    end
    else
    begin
      level <= next_level;
      item  <= next_item;
      sub   <= next_sub;
    end
  end

  // fast run counts short pushes spaced closer than the quick gap
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      quiet_cnt <= 32'h0;
      short_run <= 3'h0;
      fast      <= 1'b0;
    end
    else if (push.short_push || push.long_push)
    begin
      quiet_cnt <= 32'h0;
      short_run <= push.short_push ? next_run : 3'h0;
      if (push.short_push && next_run == FAST_PUSH_COUNT)
        fast <= 1'b1;
    end
    else
    begin
      if (quiet_cnt != 32'hffffffff)
        quiet_cnt <= quiet_cnt + 32'h1;
      if (quiet_cnt >= IDLE_CYCLES - 1)
        fast <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      edit_val   <= 16'h0;
      step_down  <= 1'b0;
      EDIT_STORE <= 1'b0;
    end
    else
    begin
      EDIT_STORE <= in_edit && push.long_push;
      if (level == LVL_SUB && push.long_push)
      begin
        edit_val  <= EDIT_INIT;
        step_down <= 1'b0;
      end
      else if (level == LVL_EDIT_HOLD && push.long_push)
        step_down <= ~step_down;
      else if (in_edit && push.short_push)
        edit_val <= step_down ? val_down : val_up;
    end
  end

  // display follows the registered menu position, so it changes two cycles after the push
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      MENU_LEVEL <= LVL_TOP;
      MENU_ITEM  <= ITEM_BATTERY_VOLTAGE;
      MENU_SUB   <= 2'h0;
      DISP_VALUE <= 17'h0;
      DISP_FLASH <= 1'b0;
      FAST_MODE  <= 1'b0;
      EDIT_VALUE <= 16'h0;
    end
    else
    begin
      MENU_LEVEL <= level;
      MENU_ITEM  <= item;
      MENU_SUB   <= sub;
      DISP_FLASH <= in_edit;
      FAST_MODE  <= fast;
      EDIT_VALUE <= edit_val;
      case (level)
        LVL_TOP:
          DISP_VALUE <= item == ITEM_BATTERY_VOLTAGE ? {1'b0, BATTERY_MV} :
                        item == ITEM_TOTAL_CHARGE ? TOTAL_CURRENT : {1'b0, EDIT_INIT};
        LVL_REGSTATE:
          DISP_VALUE <= (chg == bulk_state || chg == maintain_state) ?
                        {1'b0, BATTERY_MV} : {1'b0, state_min};
        LVL_EDIT_FLASH,
        LVL_EDIT_HOLD:
          DISP_VALUE <= {1'b0, edit_val};
        default:
          DISP_VALUE <= {1'b0, EDIT_INIT};
      endcase
    end
  end

endmodule : bcsm_top

// *** test/bcsm_top_monitor.sv ***
// Purpose: port-level checker for bcsm_top
// Assumes: one clock domain, reset active low
// Notes:   bound to every bcsm_top instance
`timescale 1ns/1ps
module bcsm_top_monitor
  import bcsm_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // measurements and settings
  input wire logic [15:0] BATTERY_MV,
  input wire logic [15:0] INTERNAL_CHARGE_CURRENT,
  input wire logic [15:0] EXTERNAL_CHARGE_CURRENT,
  input wire logic        OVERHEAT,
  input bcsm_cfg_t        CFG,
  // observed outputs
  input bcsm_chg_t        CHARGE_STATE,
  input wire logic        CHARGE_ON,
  input wire logic [7:0]  CHARGE_DUTY,
  input wire logic [16:0] TOTAL_CURRENT,
  input bcsm_level_t      MENU_LEVEL,
  input wire logic [16:0] DISP_VALUE,
  input wire logic        DISP_FLASH,
  input wire logic        FAST_MODE,
  input wire logic        EDIT_STORE
);
  // cycles since release; state checks trust $past once it saturates, the total check once it is nonzero
  logic [1:0] up;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  chk_total_sum:
  assert property (up != 2'h0 |-> TOTAL_CURRENT == {1'b0, $past(INTERNAL_CHARGE_CURRENT)}
    + {1'b0, $past(EXTERNAL_CHARGE_CURRENT)}) else $error("total current wrong");
  chk_bulk_on:
  assert property (up == 2'h3 && CHARGE_STATE == bulk_state && $past(CHARGE_STATE) ==
    bulk_state |-> CHARGE_ON) else $error("bulk not charging");
  chk_hold_reg:
  assert property (up == 2'h3 && CHARGE_STATE == hold_state && $past(CHARGE_STATE) == hold_state
    |-> CHARGE_ON == ($past(BATTERY_MV) < $past(CFG.hold_voltage))) else $error("hold reg");
  chk_maintain_reg:
  assert property (up == 2'h3 && CHARGE_STATE == maintain_state && $past(CHARGE_STATE) ==
    maintain_state |-> CHARGE_ON == ($past(BATTERY_MV) < $past(CFG.maintain_voltage)))
    else $error("maintain reg");
  chk_zero_skip:
  assert property ($changed(CHARGE_STATE) |-> !(CHARGE_STATE == equalise_state &&
    $past(CFG.equalise_duration) == 16'h0) && !(CHARGE_STATE == hold_state &&
    $past(CFG.hold_duration) == 16'h0)) else $error("zero state entered");
  chk_hot_duty:
  assert property (OVERHEAT [*4] |=> CHARGE_DUTY == HOT_DUTY) else $error("no derating");
  chk_flash_level:
  assert property (MENU_LEVEL == $past(MENU_LEVEL) |-> DISP_FLASH ==
    (MENU_LEVEL == LVL_EDIT_FLASH)) else $error("flash level");
  chk_store_pulse:
  assert property (EDIT_STORE |-> DISP_FLASH ##1 (!EDIT_STORE && !DISP_FLASH))
    else $error("store pulse long");
  chk_state_volt:
  assert property ((MENU_LEVEL == LVL_REGSTATE && (CHARGE_STATE == bulk_state ||
    CHARGE_STATE == maintain_state) && $stable(BATTERY_MV)) [*3]
    |-> DISP_VALUE == {1'b0, BATTERY_MV}) else $error("state screen value");
  cover property (EDIT_STORE);
  cover property (FAST_MODE);
  cover property (CHARGE_STATE == equalise_state);
endmodule : bcsm_top_monitor
bind bcsm_top bcsm_top_monitor bcsm_top_monitor_i (.CLK, .RSTN, .BATTERY_MV,
  .INTERNAL_CHARGE_CURRENT, .EXTERNAL_CHARGE_CURRENT, .OVERHEAT, .CFG, .CHARGE_STATE,
  .CHARGE_ON, .CHARGE_DUTY, .TOTAL_CURRENT, .MENU_LEVEL, .DISP_VALUE, .DISP_FLASH,
  .FAST_MODE, .EDIT_STORE);

// *** test/bcsm_user.sv ***
// Purpose: front panel user pressing the button
// Assumes: pin active low, idle high
// Notes:   every press starts with one bounce
`timescale 1ns/1ps
module bcsm_user
  import bcsm_pkg::*;
(
  // clock
  input  wire logic clk,
  // button pin
  output logic      button_n
);
  initial button_n = 1'b1;
  // hold length picks short or long push
  task press(input int hold);
    @(posedge clk) #1 button_n = 1'b0;
    @(posedge clk) #1 button_n = 1'b1;
    @(posedge clk) #1 button_n = 1'b0;
    repeat (hold) @(posedge clk);
    #1 button_n = 1'b1;
    repeat (12) @(posedge clk);
    #1;
  endtask : press
endmodule : bcsm_user

// *** test/bcsm_top_tb.sv ***
// Purpose: self-checking bench for bcsm_top
// Assumes: 10 cycle second, shortened button timing
// Notes:   four-day equalise limit not run, too long
`timescale 1ns/1ps
module bcsm_top_tb
  import bcsm_pkg::*;
;
  localparam logic [15:0] BULK_MAX_VOLTAGE = 16'h3840;
  localparam logic [15:0] LOW  = 16'h32c8;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] bat_mv = 16'h32c8;
  logic [15:0] cur_int = 16'h0;
  logic [15:0] cur_ext = 16'h0;
  logic [4:0]  hour = 5'h0c;
  logic        hot = 1'b0;
  bcsm_cfg_t   cfg = '{BULK_MAX_VOLTAGE, 16'h30d4, 16'h3a98, 16'h36b0, 16'h34bc, 16'h0190, 16'h0005,
                       16'h0001, 8'h00, 8'h00};
  logic        button_n;
  bcsm_chg_t   state;
  logic [7:0]  duty;
  logic [16:0] total;
  bcsm_level_t lvl;
  logic [2:0]  item;
  logic        fast;
  logic [15:0] edit;
  logic        store;
  logic [15:0] ed_init = 16'h0064;
  logic        on;
  logic [1:0]  sub;
  logic [16:0] disp;
  logic        flash;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_store = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (store === 1'b1) n_store++;
  bcsm_top #(.SEC_CYCLES(10), .DEBOUNCE_CYCLES(4), .LONG_CYCLES(40), .QUICK_CYCLES(60),
    .IDLE_CYCLES(120)) bcsm_top_i (.CLK(clk), .RSTN(rstn), .BATTERY_MV(bat_mv),
    .INTERNAL_CHARGE_CURRENT(cur_int), .EXTERNAL_CHARGE_CURRENT(cur_ext), .TIME_HOUR(hour),
    .OVERHEAT(hot), .CFG(cfg), .EDIT_INIT(ed_init), .BUTTON_N(button_n),
    .CHARGE_STATE(state), .CHARGE_ON(on), .CHARGE_DUTY(duty), .TOTAL_CURRENT(total),
    .MENU_LEVEL(lvl), .MENU_ITEM(item), .MENU_SUB(sub), .DISP_VALUE(disp), .DISP_FLASH(flash),
    .FAST_MODE(fast), .EDIT_VALUE(edit), .EDIT_STORE(store));
  bcsm_user bcsm_user_i (.clk(clk), .button_n(button_n));
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task chk(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task sp();
    bcsm_user_i.press(8);
  endtask : sp
  task lp();
    bcsm_user_i.press(55);
  endtask : lp
  // bounded wait; the range checks how long the dwell took
  task wait_st(input bcsm_chg_t exp, input int lo, input int hi);
    int n;
    n = 0;
    while (state !== exp && n <= hi)
    begin
      cyc(1);
      n++;
    end
    chk(state, exp);
    chk({16'h0, n >= lo && n <= hi}, 17'h1);
  endtask : wait_st
  task t_auto();
    bat_mv = BULK_MAX_VOLTAGE;
    wait_st(hold_state, 1780, 1830);
    cyc(300);
    bat_mv = LOW;
    cyc(400);
    chk(state, hold_state);
    bat_mv = BULK_MAX_VOLTAGE;
    wait_st(maintain_state, 270, 330);
    cyc(2);
    chk(on, 1'b0);
    bat_mv = 16'h2ee0;
    cyc(2);
    chk(on, 1'b1);
    wait_st(bulk_state, 5990, 6060);
    bat_mv = LOW;
  endtask : t_auto
  task t_manual();
    lp();
    chk(lvl, LVL_REGSTATE);
    for (int i = 1; i < 5; i++)
    begin
      lp();
      chk(state, bcsm_chg_t'(i[1:0]));
      chk(disp, (i == 1 || i == 2) ? 17'h0 : {1'b0, LOW});
    end
    cfg.equalise_duration = 16'h0;
    cfg.hold_duration = 16'h0;
    lp();
    chk(state, maintain_state);
    sp();
    chk(lvl, LVL_TOP);
    chk(state, maintain_state);
    cfg.equalise_duration = 16'h0005;
    cfg.hold_duration = 16'h0001;
  endtask : t_manual
  task t_sched();
    cfg.equalise_interval_days = 8'h01;
    hour = 5'h17;
    cyc(5);
    hour = 5'h00;
    cyc(5);
    hour = 5'h08;
    cyc(20);
    chk(state, maintain_state);
    hour = 5'h09;
    wait_st(equalise_state, 0, 10);
    cfg.equalise_interval_days = 8'h00;
    cfg.bulk_interval_days = 8'h02;
    hour = 5'h17;
    cyc(5);
    chk(state, equalise_state);
    hour = 5'h00;
    wait_st(bulk_state, 0, 10);
    cfg.bulk_interval_days = 8'h00;
  endtask : t_sched
  task t_edit();
    int k;
    sp();
    chk(item, 3'h1);
    lp();
    chk(lvl, LVL_SUB);
    lp();
    chk(edit, 16'h0064);
    chk(flash, 1'b1);
    sp();
    chk(edit, 16'h0065);
    k = n_store;
    lp();
    chk(n_store, k + 1);
    chk(lvl, LVL_EDIT_HOLD);
    chk(flash, 1'b0);
    lp();
    sp();
    chk(edit, 16'h0064);
    repeat (5) sp();
    chk(fast, 1'b1);
    chk(lvl, LVL_EDIT_FLASH);
    cyc(150);
    chk(fast, 1'b0);
    lp();
    sp();
    chk(lvl, LVL_SUB);
    repeat (3) sp();
    chk(sub, 2'h3);
    sp();
    chk(lvl, LVL_TOP);
    repeat (6) sp();
    chk(item, 3'h0);
  endtask : t_edit
  task t_misc();
    chk(disp, {1'b0, LOW});
    cur_int = 16'hffff;
    cur_ext = 16'hffff;
    cyc(2);
    chk(total, 17'h1fffe);
    hot = 1'b1;
    cyc(6);
    chk(duty, HOT_DUTY);
    hot = 1'b0;
    cyc(6);
    chk(duty, FULL_DUTY);
  endtask : t_misc
  task final_report();
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    cyc(5);
    rstn = 1'b1;
    cyc(2);
    chk(lvl, LVL_TOP);
    chk(item, ITEM_BATTERY_VOLTAGE);
    chk(state, bulk_state);
    t_auto();
    t_manual();
    t_sched();
    t_edit();
    t_misc();
    final_report();
  end
  // about three times the expected run
  initial
  begin
    cyc(30000);
    n_mismatch++;
    final_report();
  end
endmodule : bcsm_top_tb
